// *** logic/sefe_pkg.sv ***
// Constants, state codes and timing figures of the serial memory slave front end.
// Assumes a 25 MHz system clock and a master that supplies the serial clock.
package sefe_pkg;

   localparam int         SEFE_CLK_PERIOD_NS = 40;
   localparam int         SEFE_WR_TIME_NS    = 5000000;
   localparam int         SEFE_WR_CYCLES     = (SEFE_WR_TIME_NS + SEFE_CLK_PERIOD_NS - 1) / SEFE_CLK_PERIOD_NS;
   localparam int         SEFE_IDLE_TIME_NS  = 120;
   localparam int         SEFE_IDLE_CYCLES   = (SEFE_IDLE_TIME_NS + SEFE_CLK_PERIOD_NS - 1) / SEFE_CLK_PERIOD_NS;
   localparam logic [1:0] SEFE_IDLE_LAST     = 2'(SEFE_IDLE_CYCLES - 1);
   localparam logic [3:0] SEFE_DEV_TYPE_DFLT = 4'h5; // Arbitrary value.
   localparam logic [2:0] SEFE_BIT_LAST      = 3'h7;
   localparam logic [1:0] SEFE_IDX_SELECT    = 2'h0;
   localparam logic [1:0] SEFE_IDX_DATA      = 2'h3;
   localparam logic [7:0] SEFE_TX_FILL       = 8'hFF;
   localparam logic [7:0] SEFE_BYTE_RST      = 8'h00;
   localparam int         SEFE_SEL_TYPE_MSB  = 7;
   localparam int         SEFE_SEL_TYPE_LSB  = 4;
   localparam int         SEFE_SEL_CS_MSB    = 3;
   localparam int         SEFE_SEL_CS_LSB    = 1;
   localparam int         SEFE_SEL_RW        = 0;

   typedef enum logic [2:0] {
      SEFE_IDLE = 3'h0,
      SEFE_RXB  = 3'h1,
      SEFE_ACK  = 3'h3,
      SEFE_TXB  = 3'h2,
      SEFE_MACK = 3'h6
   } sefe_state_type;

endpackage : sefe_pkg

// *** logic/sefe_sync2.sv ***
// Two flip-flop level synchroniser of configurable width.
// Assumes each bit is an independent level that is stable for several destination clocks.
`timescale 1ns/1ps
`default_nettype none
module sefe_sync2
   import sefe_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sefe_sync_type;

   sefe_sync_type r_q;
   sefe_sync_type r_d;

   always_comb begin
      r_d    = r_q;
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk) begin
      r_q <= r_d;
   end

   assign q = r_q.s2;

endmodule : sefe_sync2
`default_nettype wire

// *** logic/sefe_front_end.sv ***
// Two-wire serial slave front end of a serial memory: framing, select match, acknowledge, write cycle timer.
// Assumes link_scl is the master's serial clock as its own domain and sda is resolved open drain outside.
//
// Summary of operation
// - Acts only as slave; bit logic is clocked by the master's serial clock.
// - Device pulls data low in the ninth slot after each received byte it accepts.
// - While power-on reset is high nothing on the bus is answered.
// - Select bits b3..b1 are compared with the three chip select inputs.
// - An open chip select input counts as low.
// - Write protect low allows writes; high blocks all writes.
// - An open write protect input counts as low.
// - With write protect high, select and address bytes ack, data bytes do not.
// - START is data falling while the serial clock is high.
// - START is watched for always, except during reset and the write cycle.
// - STOP is data rising while the clock is high; it ends the transfer.
// - STOP closing a read gives standby only after a master no-ack.
// - STOP closing a write starts the timed internal write cycle.
// - Transmitter releases data after eight bits; receiver pulls low in slot nine.
// - Data pin is only ever pulled low, never driven high.
// - Last select bit: one means read, zero means write.
// - On select mismatch no ack is given and the device goes to standby.
// - Data is sampled on the rising clock edge; master changes it while low.
// - Only STOP straight after a write's ack slot starts the write cycle.
`timescale 1ns/1ps
`default_nettype none
module sefe_front_end
   import sefe_pkg::*;
#(
   parameter int         WR_CYCLES = SEFE_WR_CYCLES,
   parameter logic [3:0] DEV_TYPE  = SEFE_DEV_TYPE_DFLT
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       link_scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [2:0] chip_select_inputs,
   input  wire logic       write_protect_input,
   output logic            busy,
   output logic            standby,
   output logic            wr_start,
   output logic            rx_valid,
   output logic            rx_is_data,
   output logic [7:0]      rx_byte
);

   localparam int WCW = (WR_CYCLES > 1) ? $clog2(WR_CYCLES) : 1;

   typedef struct packed {
      sefe_state_type st;
      logic [2:0]     cnt;
      logic [1:0]     idx;
      logic [7:0]     sh;
      logic [7:0]     tx;
      logic           rw;
      logic           acked;
      logic           armed;
      logic           ropen;
      logic           sel;
      logic           oe;
      logic           act;
      logic           tgl;
      logic [7:0]     rxb;
      logic           rxd;
   } sefe_link_type;

   typedef struct packed {
      logic           clr;
      logic [1:0]     clr_hist;
      logic           idle;
      logic [1:0]     qcnt;
      logic           cand;
      logic           act_prev;
      logic           tgl_prev;
      logic           hold;
      logic           busy;
      logic [WCW-1:0] wcnt;
      logic           standby;
      logic           wr_start;
      logic           rx_valid;
      logic           rx_is_data;
      logic [7:0]     rx_byte;
      logic           sda_o;
   } sefe_sys_type;

   localparam sefe_link_type LINK_RST = '{
      st: SEFE_IDLE, cnt: 3'h0, idx: SEFE_IDX_SELECT, sh: SEFE_BYTE_RST, tx: SEFE_TX_FILL,
      rw: 1'b0, acked: 1'b0, armed: 1'b0, ropen: 1'b0, sel: 1'b0, oe: 1'b0,
      act: 1'b0, tgl: 1'b0, rxb: SEFE_BYTE_RST, rxd: 1'b0};

   sefe_link_type l_q;
   sefe_link_type l_d;
   sefe_sys_type  m_q;
   sefe_sys_type  m_d;
   logic          sda_pos_q;
   logic [2:0]    cs_s;
   logic          wp_s;
   logic [1:0]    sys_in_s;
   logic [4:0]    link_st_s;
   logic          scl_s;
   logic          sda_s;
   logic          act_s;
   logic          tgl_s;
   logic          armed_s;
   logic          ropen_s;
   logic          sel_s;

   // Pin levels for the link side; unconnected inputs are pulled low at the pad.
   sefe_sync2 #(.W(4)) u_pin_sync (
      .clk (link_scl),
      .d   ({chip_select_inputs, write_protect_input}),
      .q   ({cs_s, wp_s})
   );

   // Bus levels and link-side state brought into the system clock.
   sefe_sync2 #(.W(2)) u_bus_sync (
      .clk (mclk),
      .d   ({link_scl, sda_in}),
      .q   (sys_in_s)
   );

   sefe_sync2 #(.W(5)) u_state_sync (
      .clk (mclk),
      .d   ({l_q.act, l_q.tgl, l_q.armed, l_q.ropen, l_q.sel}),
      .q   (link_st_s)
   );

   assign {scl_s, sda_s}                          = sys_in_s;
   assign {act_s, tgl_s, armed_s, ropen_s, sel_s} = link_st_s;

   // Data is taken on the rising serial clock edge.
   always_ff @(posedge link_scl or posedge m_q.clr) begin
      if (m_q.clr) begin
         sda_pos_q <= 1'b1;
      end else begin
         sda_pos_q <= sda_in;
      end
   end

   // Link engine: all bit work is done on the falling serial clock edge.
   always_comb begin
      logic [7:0] full;
      logic       match;
      full    = {l_q.sh[6:0], sda_pos_q};
      match   = 1'b0;
      l_d     = l_q;
      l_d.act = ~l_q.act;
      l_d.armed = 1'b0;
      if (sda_pos_q && !sda_in) begin
         // Data fell while the clock was high.
         l_d.st  = SEFE_RXB;
         l_d.cnt = 3'h0;
         l_d.idx = SEFE_IDX_SELECT;
         l_d.oe  = 1'b0;
         l_d.sel = 1'b0;
         l_d.ropen = 1'b0;
      end else if (!sda_pos_q && sda_in) begin
         // Data rose while the clock was high.
         l_d.st  = SEFE_IDLE;
         l_d.oe  = 1'b0;
         l_d.sel = 1'b0;
      end else begin
         unique case (l_q.st)
            SEFE_IDLE: begin
               l_d.oe = 1'b0;
            end
            SEFE_RXB: begin
               l_d.sh  = full;
               l_d.cnt = 3'(l_q.cnt + 3'h1);
               if (l_q.cnt == SEFE_BIT_LAST) begin
                  l_d.st  = SEFE_ACK;
                  l_d.cnt = 3'h0;
                  if (l_q.idx == SEFE_IDX_SELECT) begin
                     match = (full[SEFE_SEL_TYPE_MSB:SEFE_SEL_TYPE_LSB] == DEV_TYPE) &&
                             (full[SEFE_SEL_CS_MSB:SEFE_SEL_CS_LSB] == cs_s);
                     l_d.acked = match;
                     l_d.rw    = full[SEFE_SEL_RW];
                     l_d.sel   = match;
                     if (!match) begin
                        l_d.st = SEFE_IDLE;
                     end
                  end else begin
                     // Data bytes are refused under write protect.
                     l_d.acked = (l_q.idx != SEFE_IDX_DATA) || !wp_s;
                     if (l_d.acked) begin
                        l_d.tgl = ~l_q.tgl;
                        l_d.rxb = full;
                        l_d.rxd = (l_q.idx == SEFE_IDX_DATA);
                     end
                  end
                  l_d.oe = l_d.acked;
               end
            end
            SEFE_ACK: begin
               l_d.oe = 1'b0;
               l_d.armed = l_q.acked && !l_q.rw && (l_q.idx == SEFE_IDX_DATA);
               if (l_q.rw && (l_q.idx == SEFE_IDX_SELECT)) begin
                  l_d.st  = SEFE_TXB;
                  l_d.tx  = SEFE_TX_FILL;
                  l_d.oe  = !SEFE_TX_FILL[7];
                  l_d.cnt = 3'h0;
               end else begin
                  l_d.st = SEFE_RXB;
                  if (l_q.idx != SEFE_IDX_DATA) begin
                     l_d.idx = 2'(l_q.idx + 2'h1);
                  end
               end
            end
            SEFE_TXB: begin
               l_d.cnt = 3'(l_q.cnt + 3'h1);
               if (l_q.cnt == SEFE_BIT_LAST) begin
                  l_d.st  = SEFE_MACK;
                  l_d.oe  = 1'b0;
                  l_d.cnt = 3'h0;
               end else begin
                  l_d.tx = {l_q.tx[6:0], 1'b1};
                  l_d.oe = !l_q.tx[6];
               end
            end
            SEFE_MACK: begin
               if (!sda_pos_q) begin
                  // Master acknowledged; the next byte follows.
                  l_d.st    = SEFE_TXB;
                  l_d.tx    = SEFE_TX_FILL;
                  l_d.oe    = !SEFE_TX_FILL[7];
                  l_d.ropen = 1'b1;
               end else begin
                  l_d.st    = SEFE_IDLE;
                  l_d.ropen = 1'b0;
                  l_d.sel   = 1'b0;
               end
            end
            default: begin
               l_d.st = SEFE_IDLE;
               l_d.oe = 1'b0;
            end
         endcase
      end
   end

   // The link engine is held clear by reset, bus idle and the write cycle.
   always_ff @(negedge link_scl or posedge m_q.clr) begin
      if (m_q.clr) begin
         l_q <= LINK_RST;
      end else begin
         l_q <= l_d;
      end
   end

   // System side: bus idle tracking, write cycle timer and received byte hand-off.
   always_comb begin
      logic act_chg;
      logic quiet;
      logic start_wr;
      act_chg       = (act_s != m_q.act_prev);
      quiet         = m_q.cand && scl_s && sda_s && !act_chg;
      start_wr      = 1'b0;
      m_d           = m_q;
      m_d.act_prev  = act_s;
      m_d.tgl_prev  = tgl_s;
      m_d.wr_start  = 1'b0;
      m_d.rx_valid  = 1'b0;
      m_d.sda_o     = 1'b0;
      m_d.clr_hist  = {m_q.clr_hist[0], m_q.clr};
      if (act_chg) begin
         m_d.cand = 1'b0;
      end else if (scl_s && !sda_s) begin
         m_d.cand = 1'b1;
      end
      if (!m_q.idle) begin
         m_d.qcnt = quiet ? 2'(m_q.qcnt + 2'h1) : 2'h0;
         if (quiet && (m_q.qcnt == SEFE_IDLE_LAST)) begin
            // Data rose with the clock high and no clock edge since.
            m_d.idle = 1'b1;
            m_d.cand = 1'b0;
            m_d.qcnt = 2'h0;
            m_d.hold = ropen_s;
            start_wr = armed_s;
         end
      end else if ((scl_s && !sda_s) || act_chg) begin
         m_d.idle = 1'b0;
         m_d.hold = 1'b0;
      end
      if (start_wr && !m_q.busy) begin
         m_d.busy     = 1'b1;
         m_d.wr_start = 1'b1;
         m_d.wcnt     = WCW'(WR_CYCLES - 1);
      end else if (m_q.busy) begin
         if (m_q.wcnt == '0) begin
            m_d.busy = 1'b0;
         end else begin
            m_d.wcnt = WCW'(m_q.wcnt - 1'b1);
         end
      end
      m_d.clr     = m_d.idle || m_d.busy;
      m_d.standby = !m_d.busy && !sel_s && !m_d.hold;
      if ((tgl_s != m_q.tgl_prev) && !m_q.clr && (m_q.clr_hist == 2'h0)) begin
         m_d.rx_valid   = 1'b1;
         m_d.rx_byte    = l_q.rxb;
         m_d.rx_is_data = l_q.rxd;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         m_q.clr        <= 1'b1;
         m_q.clr_hist   <= 2'h3;
         m_q.idle       <= 1'b1;
         m_q.qcnt       <= 2'h0;
         m_q.cand       <= 1'b0;
         m_q.act_prev   <= 1'b0;
         m_q.tgl_prev   <= 1'b0;
         m_q.hold       <= 1'b0;
         m_q.busy       <= 1'b0;
         m_q.wcnt       <= '0;
         m_q.standby    <= 1'b1;
         m_q.wr_start   <= 1'b0;
         m_q.rx_valid   <= 1'b0;
         m_q.rx_is_data <= 1'b0;
         m_q.rx_byte    <= SEFE_BYTE_RST;
         m_q.sda_o      <= 1'b0;
      end else begin
         m_q <= m_d;
      end
   end

   assign sda_out    = m_q.sda_o;
   assign sda_oe     = l_q.oe;
   assign busy       = m_q.busy;
   assign standby    = m_q.standby;
   assign wr_start   = m_q.wr_start;
   assign rx_valid   = m_q.rx_valid;
   assign rx_is_data = m_q.rx_is_data;
   assign rx_byte    = m_q.rx_byte;

endmodule : sefe_front_end
`default_nettype wire

// *** verification/sefe_front_end_sva.sv ***
// Port assertions for the serial memory slave front end.
// Assumes every output except sda_oe is clocked by mclk and rst is synchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module sefe_front_end_sva
   import sefe_pkg::*;
#(
   parameter int         WR_CYCLES = SEFE_WR_CYCLES,
   parameter logic [3:0] DEV_TYPE  = SEFE_DEV_TYPE_DFLT
) (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       link_scl,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic [2:0] chip_select_inputs,
   input wire logic       write_protect_input,
   input wire logic       busy,
   input wire logic       standby,
   input wire logic       wr_start,
   input wire logic       rx_valid,
   input wire logic       rx_is_data,
   input wire logic [7:0] rx_byte
);
   logic [31:0] busy_cnt_q;
   // Counts the length of the current run of busy cycles.
   always_ff @(posedge mclk) begin
      busy_cnt_q <= (rst || !busy) ? 32'h0 : busy_cnt_q + 32'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   AST_IN_RESET: assert property (disable iff (1'b0) rst [*3] |-> !sda_oe && standby && !busy && !wr_start && !rx_valid)
      else $error("outputs active during reset");
   AST_PULL_ONLY: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   AST_ACK_ONE_BIT: assert property ($rose(sda_oe) |-> ##[1:3] !sda_oe)
      else $error("acknowledge pull held too long");
   AST_WR_THEN_BUSY: assert property (wr_start |=> busy && !wr_start)
      else $error("write start not followed by busy");
   AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt_q == WR_CYCLES)
      else $error("write cycle length wrong");
   AST_BUSY_NO_ACK: assert property (busy |-> !sda_oe)
      else $error("acknowledge during write cycle");
   AST_WP_NO_WRITE: assert property (write_protect_input |-> !wr_start)
      else $error("write cycle while protected");
   AST_WP_NO_DATA: assert property (write_protect_input && rx_valid |-> !rx_is_data)
      else $error("data byte accepted while protected");
   AST_RX_HOLD: assert property (!rx_valid |-> $stable(rx_byte) && $stable(rx_is_data))
      else $error("received byte changed without valid");
   AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
      else $error("receive valid longer than one cycle");
endmodule : sefe_front_end_sva
bind sefe_front_end sefe_front_end_sva #(.WR_CYCLES(WR_CYCLES), .DEV_TYPE(DEV_TYPE)) i_sefe_front_end_sva (
   .mclk(mclk), .rst(rst), .link_scl(link_scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .chip_select_inputs(chip_select_inputs), .write_protect_input(write_protect_input), .busy(busy),
   .standby(standby), .wr_start(wr_start), .rx_valid(rx_valid), .rx_is_data(rx_is_data), .rx_byte(rx_byte));
`default_nettype wire

// *** verification/sefe_bus_master.sv ***
// Behavioural two-wire bus master: makes the serial clock and pulls the data wire low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module sefe_bus_master (
   output var logic link_scl,
   output var logic sda_pull,
   input wire logic sda_wire
);
   initial begin
      link_scl = 1'b1;
      sda_pull = 1'b0;
   end
   // One bit of 64 ns; data changes only while the clock is low.
   task automatic put_bit(input logic b, output logic r);
      #16 sda_pull = !b;
      #16 link_scl = 1'b1;
      #16 r = sda_wire;
      #16 link_scl = 1'b0;
   endtask : put_bit
   task automatic start();
      #16 sda_pull = 1'b0;
      #16 link_scl = 1'b1;
      #100 sda_pull = 1'b1;
      #240 link_scl = 1'b0;
   endtask : start
   // Data stays low under a high clock long enough for the system clock side to see it.
   task automatic stop();
      #16 sda_pull = 1'b1;
      #16 link_scl = 1'b1;
      #100 sda_pull = 1'b0;
      #400;
   endtask : stop
   task automatic send_byte(input logic [7:0] d, output logic acked);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(d[i], r);
      put_bit(1'b1, r);
      acked = (r === 1'b0);
   endtask : send_byte
   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
      put_bit(!ack, r);
   endtask : recv_byte
endmodule : sefe_bus_master
`default_nettype wire

// *** verification/sefe_front_end_test.sv ***
// Self-checking bench of the serial memory slave front end with a behavioural master.
// Assumes a pulled-up data wire that both parties only pull low.
`timescale 1ns/1ps
`default_nettype none
module sefe_front_end_test;
   import sefe_pkg::*;
   localparam int         WR_N  = 60;
   localparam logic [3:0] DEV_T = 4'h6; // Arbitrary device type.
   logic       mclk;
   logic       rst;
   logic       link_scl;
   logic       sda_pull;
   logic       sda_wire;
   logic       sda_out;
   logic       sda_oe;
   logic [2:0] cs;
   logic       wp;
   logic       busy;
   logic       standby;
   logic       wr_start;
   logic       rx_valid;
   logic       rx_is_data;
   logic [7:0] rx_byte;
   logic [8:0] rxq[$];
   int         n_mismatch;
   int         n_compared;
   int         n_wr;
   assign sda_wire = !(sda_pull || (sda_oe && !sda_out));
   sefe_front_end #(.WR_CYCLES(WR_N), .DEV_TYPE(DEV_T)) i_sefe_front_end (
      .mclk(mclk), .rst(rst), .link_scl(link_scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .chip_select_inputs(cs), .write_protect_input(wp), .busy(busy), .standby(standby),
      .wr_start(wr_start), .rx_valid(rx_valid), .rx_is_data(rx_is_data), .rx_byte(rx_byte));
   sefe_bus_master i_sefe_bus_master (.link_scl(link_scl), .sda_pull(sda_pull), .sda_wire(sda_wire));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = !mclk;
   end
   // Records every reported byte and every write cycle start.
   always @(posedge mclk) begin
      if (rx_valid === 1'b1) rxq.push_back({rx_is_data, rx_byte});
      if (wr_start === 1'b1) n_wr++;
   end
   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask : chk
   task automatic m_send(input logic [7:0] d, input logic exp, input string what);
      logic a;
      i_sefe_bus_master.send_byte(d, a);
      chk(a, exp, what);
   endtask : m_send
   task automatic wait_busy(input logic lvl);
      for (int k = 0; k < 200 && busy !== lvl; k++) @(posedge mclk);
   endtask : wait_busy
   task automatic set_in(input logic [2:0] c, input logic w);
      @(negedge mclk);
      cs = c;
      wp = w;
   endtask : set_in
   task automatic t_write();
      rxq.delete();
      set_in(3'h5, 1'b0);
      i_sefe_bus_master.start();
      m_send({DEV_T, 3'h5, 1'b0}, 1'b1, "select not acked");
      m_send(8'h3C, 1'b1, "address high not acked");
      m_send(8'hC3, 1'b1, "address low not acked");
      m_send(8'h5A, 1'b1, "data not acked");
      i_sefe_bus_master.stop();
      wait_busy(1'b1);
      chk({busy, n_wr[7:0]}, {1'b1, 8'h01}, "no write cycle");
      i_sefe_bus_master.start();
      m_send({DEV_T, 3'h5, 1'b0}, 1'b0, "acked while busy");
      i_sefe_bus_master.stop();
      wait_busy(1'b0);
      chk(busy, 1'b0, "write cycle did not end");
      chk(rxq.size(), 9'h3, "received byte count");
      foreach (rxq[i]) chk(rxq[i], (i == 0) ? 9'h03C : (i == 1) ? 9'h0C3 : 9'h15A, "received byte");
      i_sefe_bus_master.start();
      m_send({DEV_T, 3'h5, 1'b0}, 1'b1, "not acked after write cycle");
      m_send(8'h11, 1'b1, "address high not acked");
      i_sefe_bus_master.stop();
      chk(n_wr, 9'h1, "write cycle without data");
   endtask : t_write
   task automatic t_select();
      for (int k = 0; k < 8; k++) begin
         set_in(3'(k), 1'b0);
         i_sefe_bus_master.start();
         m_send({DEV_T, 3'(k), 1'b0}, 1'b1, "matching select not acked");
         i_sefe_bus_master.stop();
         i_sefe_bus_master.start();
         m_send({DEV_T, 3'(k) ^ 3'h2, 1'b0}, 1'b0, "wrong chip select acked");
         i_sefe_bus_master.stop();
         chk(standby, 1'b1, "not in standby after mismatch");
      end
      i_sefe_bus_master.start();
      m_send({DEV_T ^ 4'h8, 3'h7, 1'b0}, 1'b0, "wrong device type acked");
      i_sefe_bus_master.stop();
      chk(n_wr, 9'h1, "write cycle after select only");
   endtask : t_select
   task automatic t_protect();
      rxq.delete();
      set_in(3'h2, 1'b1);
      i_sefe_bus_master.start();
      m_send({DEV_T, 3'h2, 1'b0}, 1'b1, "select not acked when protected");
      m_send(8'h01, 1'b1, "address high not acked when protected");
      m_send(8'h02, 1'b1, "address low not acked when protected");
      m_send(8'hA5, 1'b0, "data acked when protected");
      i_sefe_bus_master.stop();
      repeat (20) @(posedge mclk);
      chk({busy, n_wr[7:0], rxq.size() == 2}, {1'b0, 8'h01, 1'b1}, "protected write went through");
      set_in(3'h2, 1'b0);
   endtask : t_protect
   task automatic t_read(input logic last_ack);
      logic [7:0] d;
      i_sefe_bus_master.start();
      m_send({DEV_T, 3'h2, 1'b1}, 1'b1, "read select not acked");
      repeat (4) @(posedge mclk);
      chk(standby, 1'b0, "standby while selected");
      i_sefe_bus_master.recv_byte(1'b1, d);
      chk(d, SEFE_TX_FILL, "read data");
      i_sefe_bus_master.recv_byte(last_ack, d);
      i_sefe_bus_master.stop();
      chk(standby, !last_ack, "standby after read stop");
   endtask : t_read
   task automatic t_reset();
      @(negedge mclk);
      rst = 1'b1;
      i_sefe_bus_master.start();
      m_send({DEV_T, 3'h2, 1'b0}, 1'b0, "acked under reset");
      i_sefe_bus_master.stop();
      @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(posedge mclk);
      m_send({DEV_T, 3'h2, 1'b0}, 1'b0, "acked without start");
      i_sefe_bus_master.stop();
   endtask : t_reset
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      n_wr = 0;
      rst = 1'b1;
      cs = 3'h0;
      wp = 1'b0;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(posedge mclk);
      t_write();
      t_select();
      t_protect();
      t_read(1'b0);
      t_read(1'b1);
      t_reset();
      t_read(1'b0);
      tally_and_finish();
   end
   initial begin
      #2000000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : sefe_front_end_test
`default_nettype wire
